// file: rtl/ims_pkg.sv
package ims_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] IMS_OFF_STB = 8'h00;
  localparam logic [7:0] IMS_OFF_SRE = 8'h04;
  localparam logic [7:0] IMS_OFF_ESR = 8'h08;
  localparam logic [7:0] IMS_OFF_ESE = 8'h0C;
  localparam logic [7:0] IMS_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] IMS_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] IMS_OFF_STATE = 8'h18;

  // status byte bit positions
  localparam int IMS_STB_OESB = 1;
  localparam int IMS_STB_HESB = 2;
  localparam int IMS_STB_MAV = 4;
  localparam int IMS_STB_ESB = 5;
  localparam int IMS_STB_RQS = 6;
  localparam int IMS_STB_OSB = 7;

  // standard event status bit for operation complete
  localparam int IMS_ESR_OPC = 0;

  // interrupt status / mask bit positions
  localparam int IMS_IRQ_SRQ = 0;
  localparam int IMS_IRQ_OPC = 1;
  localparam int IMS_IRQ_MAV = 2;
  localparam int IMS_IRQ_OPCQ = 3;
  localparam int IMS_IRQ_W = 4;

  // state register bit positions
  localparam int IMS_ST_OPC_ARMED = 0;
  localparam int IMS_ST_BUS_HOLD = 1;
  localparam int IMS_ST_RQS = 2;
  localparam int IMS_ST_MSS = 3;

  // reset values
  localparam logic [7:0] IMS_SRE_RST = 8'h00;
  localparam logic [7:0] IMS_ESE_RST = 8'h00;
  localparam logic [7:0] IMS_ESR_RST = 8'h00;
  localparam logic [IMS_IRQ_W-1:0] IMS_IRQ_RST = 4'h0;

  // response byte for the operation-complete query: ASCII '1'
  localparam logic [7:0] IMS_OPCQ_CHAR = 8'h31;

  // output buffer geometry
  localparam int IMS_BUF_DEPTH = 16;
  localparam int IMS_BUF_AW = 4;

  // operation-complete tracker states
  typedef enum logic [2:0] {
    IMS_OP_IDLE = 3'b001,
    IMS_OP_ARMED = 3'b010,
    IMS_OP_HOLD = 3'b100
  } ims_op_e;

endpackage

// file: rtl/ims_resp_buf.sv
`timescale 1ns/10ps
module ims_resp_buf
  import ims_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // fill side
  input wire logic push,
  input wire logic [7:0] push_data,
  output logic full,
  // drain side
  input wire logic pop,
  output logic [7:0] pop_data,
  output logic pop_valid,
  output logic empty
);

  logic [7:0] mem [IMS_BUF_DEPTH];
  logic [IMS_BUF_AW-1:0] wr_ptr_reg;
  logic [IMS_BUF_AW-1:0] rd_ptr_reg;
  logic [IMS_BUF_AW:0] count_reg;
  logic do_push;
  logic do_pop;

  assign empty = (count_reg == '0);
  assign full = (count_reg == (IMS_BUF_AW+1)'(IMS_BUF_DEPTH));
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      unique case ({do_push, do_pop})
        2'b10: count_reg <= count_reg + 1'b1;
        2'b01: count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end

  // read data registered so the bus side sees a flop output
  always_ff @(posedge clock) begin
    if (reset) begin
      pop_data <= 8'h00;
      pop_valid <= 1'b0;
    end else begin
      pop_valid <= do_pop;
      if (do_pop) begin
        pop_data <= mem[rd_ptr_reg];
      end
    end
  end

endmodule

// file: rtl/ims_status_core.sv
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - MAV bit set while buffer holds data
// - MAV bit clear whenever buffer is empty
// - enabled MAV rising raises service request
// - *OPC sets event bit 0 at completion
// - commands still accepted while *OPC pending
// - *OPC? never touches event bit 0
// - *OPC? holds bus until operation completes
// - *OPC? completion loads '1' into buffer
// - bit 6 is OR of summary AND enable
// - poll clears RQS, MSS follows enabled bits
// - ESB summarises enabled standard event bits
module ims_status_core
  import ims_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // commands from the interpreter, one-cycle pulses
  input wire logic cmd_opc,
  input wire logic cmd_opc_query,
  input wire logic cmd_rst,
  // instrument operation in progress
  input wire logic op_busy,
  // other summary bits and standard events
  input wire logic sum_osb,
  input wire logic sum_hesb,
  input wire logic sum_oesb,
  input wire logic [7:0] std_event,
  // response bytes from the interpreter
  input wire logic resp_wr,
  input wire logic [7:0] resp_wr_data,
  output logic resp_wr_ready,
  // bus controller side
  input wire logic talk_rd,
  output logic [7:0] talk_data,
  output logic talk_valid,
  input wire logic serial_poll,
  output logic [7:0] poll_data,
  output logic poll_valid,
  output logic srq,
  output logic bus_hold,
  output logic msg_avail,
  // interrupt
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] sre_reg;
  logic [7:0] ese_reg;
  logic [7:0] esr_reg;
  logic [7:0] esr_next;
  logic [IMS_IRQ_W-1:0] irq_stat_reg;
  logic [IMS_IRQ_W-1:0] irq_mask_reg;
  logic [IMS_IRQ_W-1:0] irq_event;
  ims_op_e op_state_reg;
  ims_op_e op_state_next;
  logic rqs_reg;
  logic mss_prev_reg;
  logic [7:0] en_sum_prev_reg;
  logic mav_prev_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [7:0] stb_byte;
  logic [7:0] sum_bits;
  logic mss;
  logic [7:0] en_sum;
  logic sum_rise;
  logic mav;
  logic esb;
  logic buf_full;
  logic buf_empty;
  logic opc_done;
  logic opcq_done;
  logic buf_push;
  logic [7:0] buf_push_data;
  logic bus_req;
  logic wr_en;
  logic rd_en;
  logic [7:0] wr_byte;

  //////////////////////////////////////////////////////////////////////////////
  // output buffer and message available

  ims_resp_buf u_buf (
    .clock(clock),
    .reset(reset),
    .push(buf_push),
    .push_data(buf_push_data),
    .full(buf_full),
    .pop(talk_rd),
    .pop_data(talk_data),
    .pop_valid(talk_valid),
    .empty(buf_empty)
  );

  // no latch: MAV follows the buffer in the same cycle
  assign mav = !buf_empty;
  assign msg_avail = mav;

  // query answer wins the buffer; interpreter waits a cycle
  assign buf_push = opcq_done || (resp_wr && !buf_full);
  assign buf_push_data = opcq_done ? IMS_OPCQ_CHAR : resp_wr_data;
  assign resp_wr_ready = !buf_full && !opcq_done;

  //////////////////////////////////////////////////////////////////////////////
  // operation-complete tracker

  assign opc_done = (op_state_reg == IMS_OP_ARMED) && !op_busy;
  assign opcq_done = (op_state_reg == IMS_OP_HOLD) && !op_busy && !buf_full;

  always_comb begin
    op_state_next = op_state_reg;
    unique case (op_state_reg)
      IMS_OP_IDLE: begin
        if (cmd_opc_query) begin
          op_state_next = IMS_OP_HOLD;
        end else if (cmd_opc) begin
          op_state_next = IMS_OP_ARMED;
        end
      end
      IMS_OP_ARMED: begin
        // other commands flow on; a query replaces the watch
        if (cmd_opc_query) begin
          op_state_next = IMS_OP_HOLD;
        end else if (opc_done) begin
          op_state_next = IMS_OP_IDLE;
        end
      end
      IMS_OP_HOLD: begin
        if (opcq_done) begin
          op_state_next = IMS_OP_IDLE;
        end
      end
      default: op_state_next = IMS_OP_IDLE;
    endcase
    if (cmd_rst) begin
      op_state_next = IMS_OP_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      op_state_reg <= IMS_OP_IDLE;
    end else begin
      op_state_reg <= op_state_next;
    end
  end

  // bus stays held while the query waits on the operation
  assign bus_hold = (op_state_reg == IMS_OP_HOLD);

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request, dropped next cycle

  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wr_en = bus_req && wb_we_i && ack_reg && wb_sel_i[0];
  assign rd_en = bus_req && !wb_we_i && ack_reg;
  assign wr_byte = wb_dat_i[7:0];
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dat_reg <= 32'h0000_0000;
    end else if (bus_req && !ack_reg) begin
      unique case (wb_adr_i)
        IMS_OFF_STB: dat_reg <= {24'h000000, stb_byte};
        IMS_OFF_SRE: dat_reg <= {24'h000000, sre_reg};
        IMS_OFF_ESR: dat_reg <= {24'h000000, esr_reg};
        IMS_OFF_ESE: dat_reg <= {24'h000000, ese_reg};
        IMS_OFF_IRQ_STAT: dat_reg <= {28'h0000000, irq_stat_reg};
        IMS_OFF_IRQ_MASK: dat_reg <= {28'h0000000, irq_mask_reg};
        IMS_OFF_STATE: begin
          dat_reg <= {28'h0000000, mss, rqs_reg, bus_hold,
                      (op_state_reg == IMS_OP_ARMED)};
        end
        default: dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // enable registers

  always_ff @(posedge clock) begin
    if (reset) begin
      sre_reg <= IMS_SRE_RST;
      ese_reg <= IMS_ESE_RST;
      irq_mask_reg <= IMS_IRQ_RST;
    end else if (wr_en) begin
      if (wb_adr_i == IMS_OFF_SRE) begin
        // bit 6 cannot enable itself
        sre_reg <= wr_byte & ~(8'h01 << IMS_STB_RQS);
      end
      if (wb_adr_i == IMS_OFF_ESE) begin
        ese_reg <= wr_byte;
      end
      if (wb_adr_i == IMS_OFF_IRQ_MASK) begin
        irq_mask_reg <= wr_byte[IMS_IRQ_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // standard event status: read clears, new events win over the clear

  always_comb begin
    esr_next = esr_reg;
    if (rd_en && (wb_adr_i == IMS_OFF_ESR)) begin
      // clear only the bits the read returned, so an event landing
      // between the data latch and the ack is not lost
      esr_next = esr_reg & ~dat_reg[7:0];
    end
    esr_next = esr_next | std_event;
    // besides std_event, only the *OPC watch sets bit 0; the query path never does
    if (opc_done) begin
      esr_next[IMS_ESR_OPC] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      esr_reg <= IMS_ESR_RST;
    end else begin
      esr_reg <= esr_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status byte and service request

  assign esb = |(esr_reg & ese_reg);

  always_comb begin
    sum_bits = 8'h00;
    sum_bits[IMS_STB_OSB] = sum_osb;
    sum_bits[IMS_STB_ESB] = esb;
    sum_bits[IMS_STB_MAV] = mav;
    sum_bits[IMS_STB_HESB] = sum_hesb;
    sum_bits[IMS_STB_OESB] = sum_oesb;
  end

  assign en_sum = sum_bits & sre_reg;
  assign mss = |en_sum;
  // per-bit edges: a second enabled source can still raise a request
  assign sum_rise = |(en_sum & ~en_sum_prev_reg);

  always_ff @(posedge clock) begin
    if (reset) begin
      en_sum_prev_reg <= 8'h00;
    end else begin
      en_sum_prev_reg <= en_sum;
    end
  end

  always_comb begin
    stb_byte = sum_bits;
    stb_byte[IMS_STB_RQS] = mss;
  end

  // rqs set when any enabled summary bit rises; a poll clears it
  // and a rise in the same cycle wins
  always_ff @(posedge clock) begin
    if (reset) begin
      mss_prev_reg <= 1'b0;
      rqs_reg <= 1'b0;
    end else begin
      mss_prev_reg <= mss;
      if (sum_rise) begin
        rqs_reg <= 1'b1;
      end else if (serial_poll) begin
        rqs_reg <= 1'b0;
      end
    end
  end

  assign srq = rqs_reg;

  // poll answer carries rqs in bit 6; mss untouched by the poll
  always_ff @(posedge clock) begin
    if (reset) begin
      poll_data <= 8'h00;
      poll_valid <= 1'b0;
    end else begin
      poll_valid <= serial_poll;
      if (serial_poll) begin
        poll_data <= {sum_bits[7], rqs_reg, sum_bits[5:0]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, set wins

  always_ff @(posedge clock) begin
    if (reset) begin
      mav_prev_reg <= 1'b0;
    end else begin
      mav_prev_reg <= mav;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[IMS_IRQ_SRQ] = mss && !mss_prev_reg;
    irq_event[IMS_IRQ_OPC] = opc_done;
    irq_event[IMS_IRQ_MAV] = mav && !mav_prev_reg;
    irq_event[IMS_IRQ_OPCQ] = opcq_done;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_stat_reg <= IMS_IRQ_RST;
    end else if (wr_en && (wb_adr_i == IMS_OFF_IRQ_STAT)) begin
      irq_stat_reg <= (irq_stat_reg & ~wr_byte[IMS_IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule

// file: dv/ims_ctl_model.sv
`timescale 1ns/10ps
module ims_ctl_model(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // device side
  input wire logic en,
  input wire logic msg_avail,
  input wire logic srq,
  input wire logic talk_valid,
  input wire logic [7:0] talk_data,
  output logic talk_rd,
  output logic serial_poll,
  output logic [7:0] last_byte
);
  // one read in flight, started only once the message bit shows
  always_ff @(posedge clock) begin
    if (reset) begin
      talk_rd <= 1'h0;
      last_byte <= 8'h00;
    end else begin
      talk_rd <= en && msg_avail && !talk_rd && !talk_valid;
      if (talk_valid) begin
        last_byte <= talk_data;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      serial_poll <= 1'h0;
    end else begin
      serial_poll <= en && srq && !serial_poll;
    end
  end
endmodule

// file: dv/ims_status_core_sva.sv
`timescale 1ns/10ps
module ims_status_core_sva(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // bus, commands, buffer
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cmd_opc_query,
  input wire logic cmd_rst,
  input wire logic op_busy,
  input wire logic resp_wr,
  input wire logic resp_wr_ready,
  // controller side
  input wire logic talk_rd,
  input wire logic talk_valid,
  input wire logic serial_poll,
  input wire logic [7:0] poll_data,
  input wire logic poll_valid,
  input wire logic bus_hold,
  input wire logic msg_avail
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_query;
    cmd_opc_query && !bus_hold && !cmd_rst;
  endsequence
  sequence s_pending;
    bus_hold && op_busy && !cmd_rst;
  endsequence
  sequence s_answered;
    $fell(bus_hold) && !$past(cmd_rst);
  endsequence
  a_ack_one: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_mav_push: assert property (resp_wr && resp_wr_ready |=> msg_avail)
    else $error("mav low after push");
  a_mav_empty: assert property (talk_rd && !msg_avail |=> !talk_valid)
    else $error("byte read from empty buffer");
  a_mav_read: assert property (talk_rd && msg_avail |=> talk_valid)
    else $error("read not answered");
  a_mav_poll: assert property (
    poll_valid |-> poll_data[4] == $past(msg_avail))
    else $error("polled mav stale");
  a_poll_answer: assert property (serial_poll |=> poll_valid)
    else $error("poll not answered");
  a_hold_query: assert property (s_query |=> bus_hold)
    else $error("query did not hold bus");
  a_hold_busy: assert property (s_pending |=> bus_hold)
    else $error("bus released while busy");
  a_hold_answer: assert property (s_answered |-> msg_avail)
    else $error("no answer after hold");
endmodule
bind ims_status_core ims_status_core_sva u_sva(.clock, .reset, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .cmd_opc_query, .cmd_rst, .op_busy, .resp_wr,
  .resp_wr_ready, .talk_rd, .talk_valid, .serial_poll, .poll_data,
  .poll_valid, .bus_hold, .msg_avail);

// file: dv/testbench.sv
`timescale 1ns/10ps
module testbench
  import ims_pkg::*;
;
  logic clock = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00, resp_wr_data = 8'h00, q, b;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'hF;
  logic cmd_opc = 0, cmd_opc_query = 0, cmd_rst = 0, op_busy = 0;
  logic sum_osb = 0, sum_hesb = 0, sum_oesb = 0, resp_wr = 0, en = 0;
  logic [7:0] std_event = 8'h00, talk_data, poll_data, last_byte;
  logic [7:0] pb = 8'h00;
  logic wb_ack_o, resp_wr_ready, talk_rd, talk_valid, serial_poll;
  logic poll_valid, srq, bus_hold, msg_avail, irq;
  int miscompares = 0, n_checks = 0, seed = 76;
  always #5 clock = ~clock;
  ims_status_core u_dut(.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmd_opc,
    .cmd_opc_query, .cmd_rst, .op_busy, .sum_osb, .sum_hesb, .sum_oesb,
    .std_event, .resp_wr, .resp_wr_data, .resp_wr_ready, .talk_rd,
    .talk_data, .talk_valid, .serial_poll, .poll_data, .poll_valid, .srq,
    .bus_hold, .msg_avail, .irq);
  ims_ctl_model u_ctl(.clock, .reset, .en, .msg_avail, .srq, .talk_valid,
    .talk_data, .talk_rd, .serial_poll, .last_byte);
  // last status byte returned by a serial poll
  always @(posedge clock) begin
    if (poll_valid === 1'h1) begin
      pb <= poll_data;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, g);
    chk(n, {7'h00, e}, {7'h00, g});
  endtask
  function automatic logic [7:0] stb_exp(input logic mss, esb, mav);
    return {1'h0, mss, esb, mav, 4'h0};
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clock); while (wb_ack_o !== 1'h1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clock);
  endtask
  task automatic push(input logic [7:0] d);
    resp_wr <= 1'h1;
    resp_wr_data <= d;
    do @(posedge clock); while (resp_wr_ready !== 1'h1);
    resp_wr <= 1'h0;
    @(posedge clock);
  endtask
  // the controller only reads and polls while en is high
  task automatic drain;
    en <= 1'h1;
    for (int k = 0; k < 80 && msg_avail !== 1'h0; k++) @(posedge clock);
    repeat (3) @(posedge clock);
    en <= 1'h0;
  endtask
  task automatic pulse_hold(input logic rst);
    op_busy <= 1'h1;
    cmd_opc_query <= 1'h1;
    @(posedge clock);
    cmd_opc_query <= 1'h0;
    cmd_rst <= rst;
    @(posedge clock);
    cmd_rst <= 1'h0;
    repeat (3) @(posedge clock);
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    results();
  end
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    wb(1'h0, IMS_OFF_SRE, 8'h00);
    chk("sre", IMS_SRE_RST, q);
    wb(1'h1, 8'h1C, 8'hFF);
    wb(1'h0, 8'h1C, 8'h00);
    chk("unmapped", 8'h00, q);
    for (int k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      push(b);
      chk1("mav", 1'h1, msg_avail);
    end
    wb(1'h0, IMS_OFF_STB, 8'h00);
    chk("stb", stb_exp(1'h0, 1'h0, 1'h1), q);
    drain();
    chk("byte", b, last_byte);
    chk1("mav", 1'h0, msg_avail);
    // enabled mav raises a request; draining empties the buffer and polling drops the request
    wb(1'h1, IMS_OFF_SRE, 8'h10);
    wb(1'h1, IMS_OFF_IRQ_MASK, 8'h04);
    wb(1'h1, IMS_OFF_IRQ_STAT, 8'h0F);
    chk1("irq", 1'h0, irq);
    push(8'($random(seed)));
    repeat (3) @(posedge clock);
    chk1("srq", 1'h1, srq);
    chk1("irq", 1'h1, irq);
    wb(1'h0, IMS_OFF_STB, 8'h00);
    chk("stb", stb_exp(1'h1, 1'h0, 1'h1), q);
    wb(1'h1, IMS_OFF_IRQ_STAT, 8'h04);
    chk1("irq", 1'h0, irq);
    drain();
    chk1("srq", 1'h0, srq);
    wb(1'h0, IMS_OFF_STB, 8'h00);
    chk("stb", stb_exp(1'h0, 1'h0, 1'h0), q);
    chk("poll", stb_exp(1'h1, 1'h0, 1'h1), pb);
    wb(1'h1, IMS_OFF_ESE, 8'h01);
    wb(1'h1, IMS_OFF_SRE, 8'h20);
    op_busy <= 1'h1;
    cmd_opc <= 1'h1;
    @(posedge clock);
    cmd_opc <= 1'h0;
    b = 8'($random(seed));
    push(b);
    drain();
    chk("byte", b, last_byte);
    wb(1'h0, IMS_OFF_ESR, 8'h00);
    chk("esr", 8'h00, q);
    op_busy <= 1'h0;
    repeat (3) @(posedge clock);
    wb(1'h0, IMS_OFF_STB, 8'h00);
    chk("stb", stb_exp(1'h1, 1'h1, 1'h0), q);
    // a poll drops only the request; the summary stays
    drain();
    wb(1'h0, IMS_OFF_STATE, 8'h00);
    chk("state", 8'h01 << IMS_ST_MSS, q);
    chk("poll", stb_exp(1'h1, 1'h1, 1'h0), pb);
    // mav rising while the summary is already high asks again
    wb(1'h1, IMS_OFF_SRE, 8'h30);
    push(8'($random(seed)));
    repeat (3) @(posedge clock);
    chk1("srq", 1'h1, srq);
    drain();
    wb(1'h0, IMS_OFF_ESR, 8'h00);
    chk("esr", 8'h01, q);
    wb(1'h1, IMS_OFF_SRE, 8'h00);
    pulse_hold(1'h0);
    chk1("hold", 1'h1, bus_hold);
    chk1("mav", 1'h0, msg_avail);
    op_busy <= 1'h0;
    for (int k = 0; k < 20 && bus_hold !== 1'h0; k++) @(posedge clock);
    drain();
    chk("byte", IMS_OPCQ_CHAR, last_byte);
    wb(1'h0, IMS_OFF_ESR, 8'h00);
    chk("esr", 8'h00, q);
    pulse_hold(1'h1);
    chk1("hold", 1'h0, bus_hold);
    op_busy <= 1'h0;
    repeat (3) @(posedge clock);
    chk1("mav", 1'h0, msg_avail);
    results();
  end
endmodule
